// ==== emf_crc4_mf_sync.sv ====
// receive crc-4 multiframe alignment, check and e-bit gating
//
// Contract
// - sixteen frames, two eight-frame submultiframes in order
// - each submultiframe is one 2048-bit check block
// - fas frames bit 1 carry c1..c4
// - non-fas bit 1 holds 001011 and e bits
// - e bits evaluated even if block errored
// - e-bit monitoring stops while multiframe lost
// - remainder of x^4-multiplied block mod x^4+x+1
// - first block bit is msb, c1 msb
// - check positions zeroed before remainder computed
// - compare remainder with next block check bits
// - basic loss forces multiframe lost, then re-search
// - crc counter and second monitoring freeze
// - e-bit counter and sa6 monitoring freeze
// - option bit: one count per lost second
// - two patterns within 8 ms, 2 ms apart
// - 8 ms failure starts parallel basic search
// - default mode keeps searching continuously
// - 100 ms timer expiry declares frame loss
// - 400 ms timer reset only on basic loss
// - parallel searches leave 400 ms timer alone
// - found alignment replaces differing primary alignment
// - 400 ms expiry: no-pattern flag, crc inhibited
// - three bad alignment words mean basic loss
`include "emf_regs.svh"

module emf_crc4_mf_sync #(
  parameter int unsigned TW   = 25,
  parameter int unsigned C8   = `EMF_T8_US * `EMF_CLK_MHZ,
  parameter int unsigned C100 = `EMF_T100_US * `EMF_CLK_MHZ,
  parameter int unsigned C400 = `EMF_T400_US * `EMF_CLK_MHZ,
  parameter int unsigned C1S  = `EMF_T1S_US * `EMF_CLK_MHZ
) (
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              sys_rst_i,
  // line bits from the basic framer
  input  wire logic              rx_bit_i,
  input  wire logic              rx_bit_vld_i,
  input  wire logic              rx_frame_start_i,
  input  wire logic              rx_fas_frame_i,
  input  wire logic              basic_frame_locked_i,
  input  wire logic              fas_err_i,
  input  wire logic              fas_ok_i,
  input  wire logic              parallel_align_i,
  // configuration
  input  wire emf_pkg::emf_mode_e reframe_mode_i,
  input  wire logic              mf_lost_mon_en_i,
  // status and gating
  output logic                   multiframe_lost_o,
  output logic                   frame_align_lost_o,
  output logic                   parallel_search_o,
  output logic                   primary_replace_o,
  output logic                   no_mfa_signal_o,
  output logic                   crc_inhibit_o,
  output logic                   crc_chk_o,
  output logic                   crc_err_o,
  output logic                   ebit_zero_o,
  output logic                   perf_mon_en_o,
  output logic                   sa6_mon_en_o,
  output logic                   mf_lost_sec_tick_o
);

  localparam logic [TW-1:0] L8   = TW'(C8 - 1);
  localparam logic [TW-1:0] L100 = TW'(C100 - 1);
  localparam logic [TW-1:0] L400 = TW'(C400 - 1);
  localparam logic [TW-1:0] L1S  = TW'(C1S - 1);

  // ----------------------------------------
  // state
  // ----------------------------------------
  emf_pkg::emf_state_e st_q, st_d;
  logic [3:0]    fr_q, fr_d;
  logic [7:0]    bc_q, bc_d;
  logic [5:0]    hist_q, hist_d;
  logic [3:0]    crc_q, crc_d;
  logic [3:0]    rem_q, rem_d;
  logic          rem_vld_q, rem_vld_d;
  logic [3:0]    cb_q, cb_d;
  logic [1:0]    ferr_q, ferr_d;
  logic          lock_q, lock_d;
  logic          t400_run_q, t400_run_d;
  logic [TW-1:0] t8_q, t8_d;
  logic [TW-1:0] t100_q, t100_d;
  logic [TW-1:0] t400_q, t400_d;
  logic [TW-1:0] sec_q, sec_d;
  logic          align_lost_d, psrch_d, repl_d, chk_d, err_d, ez_d, tick_d;

  logic [3:0] fr_now;
  logic       bit1, fas_b1, match, blk_end, basic_loss;

  always_comb begin
    fr_now     = rx_frame_start_i ? fr_q + 4'h1 : fr_q;
    bit1       = rx_bit_vld_i && rx_frame_start_i;
    fas_b1     = bit1 && rx_fas_frame_i;
    match      = bit1 && !rx_fas_frame_i && ({hist_q[4:0], rx_bit_i} == `EMF_MFAS_PAT);
    blk_end    = rx_bit_vld_i && (bc_q == `EMF_LAST_BIT - 8'h01) && !rx_frame_start_i
                 && (fr_q[2:0] == 3'h7);
    basic_loss = fas_err_i && (ferr_q == `EMF_LOSS_FAS_ERRS - 2'h1);
  end

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    st_d = st_q; fr_d = fr_now; bc_d = bc_q; hist_d = hist_q;
    crc_d = crc_q; rem_d = rem_q; rem_vld_d = rem_vld_q; cb_d = cb_q;
    ferr_d = ferr_q; lock_d = basic_frame_locked_i; t400_run_d = t400_run_q;
    t8_d = t8_q; t100_d = t100_q; t400_d = t400_q; sec_d = sec_q;
    align_lost_d = 1'b0; psrch_d = 1'b0; repl_d = 1'b0;
    chk_d = 1'b0; err_d = 1'b0; ez_d = 1'b0; tick_d = 1'b0;

    // bit position inside the 256-bit frame
    if (rx_bit_vld_i) begin
      bc_d = rx_frame_start_i ? 8'h00 : bc_q + 8'h01;
    end

    // serial division, check positions forced to zero
    if (rx_bit_vld_i) begin
      crc_d = {crc_q[2:0], 1'b0} ^
              (((fas_b1 ? 1'b0 : rx_bit_i) ^ crc_q[3]) ? `EMF_CRC_POLY : 4'h0);
    end
    if (blk_end) begin
      rem_d     = crc_d;
      crc_d     = 4'h0;
      rem_vld_d = (st_q == emf_pkg::EMF_LOCKED);
    end

    // check bits sit in bit 1 of the even frames, c1 first
    if (fas_b1 && !fr_now[0]) begin
      cb_d[3 - fr_now[2:1]] = rx_bit_i;
    end
    if (fas_b1 && fr_now[2:0] == 3'h6 && st_q == emf_pkg::EMF_LOCKED && rem_vld_q) begin
      chk_d = 1'b1;
      err_d = ({cb_q[3:1], rx_bit_i} != rem_q);
    end

    // e bits in frames 13 and 15, blind to the block result
    if (bit1 && !rx_fas_frame_i && st_q == emf_pkg::EMF_LOCKED
        && (fr_now == 4'hd || fr_now == 4'hf)) begin
      ez_d = !rx_bit_i;
    end

    // pattern history only from non-fas bit 1
    if (bit1 && !rx_fas_frame_i) begin
      hist_d = {hist_q[4:0], rx_bit_i};
    end

    // consecutive bad alignment words
    if (fas_ok_i) begin
      ferr_d = 2'h0;
    end else if (fas_err_i) begin
      ferr_d = basic_loss ? 2'h0 : ferr_q + 2'h1;
    end

    // 400 ms timer: first lock starts it, only basic loss clears it
    if (reframe_mode_i == emf_pkg::EMF_MODE_400MS) begin
      if (basic_loss || !basic_frame_locked_i) begin
        t400_run_d = 1'b0;
        t400_d     = '0;
      end else if (basic_frame_locked_i && !lock_q && !t400_run_q) begin
        t400_run_d = 1'b1;
        t400_d     = '0;
      end else if (t400_run_q && st_q != emf_pkg::EMF_LOCKED && t400_q != L400) begin
        t400_d = t400_q + 1'b1;
      end
    end else begin
      t400_run_d = 1'b0;
      t400_d     = '0;
    end

    // alignment state machine
    case (st_q)
      emf_pkg::EMF_LOST: begin
        t8_d = '0; t100_d = '0;
        if (basic_frame_locked_i) begin
          st_d = emf_pkg::EMF_SEARCH;
        end
      end
      emf_pkg::EMF_SEARCH, emf_pkg::EMF_CONFIRM: begin
        t8_d   = t8_q + 1'b1;
        t100_d = t100_q + 1'b1;
        if (match) begin
          // first sighting fixes the frame count; a repeat one multiframe on confirms
          if (st_q == emf_pkg::EMF_SEARCH) begin
            st_d = emf_pkg::EMF_CONFIRM;
            fr_d = `EMF_MFAS_FRAME;
          end else if (fr_now == `EMF_MFAS_FRAME) begin
            st_d   = emf_pkg::EMF_LOCKED;
            repl_d = (reframe_mode_i == emf_pkg::EMF_MODE_400MS) && parallel_align_i;
          end
        end
        if (st_d != emf_pkg::EMF_LOCKED && t8_q == L8) begin
          psrch_d = 1'b1;
          t8_d    = '0;
          st_d    = emf_pkg::EMF_SEARCH;
        end
        if (reframe_mode_i == emf_pkg::EMF_MODE_100MS && st_d != emf_pkg::EMF_LOCKED
            && t100_q == L100) begin
          align_lost_d = 1'b1;
          st_d  = emf_pkg::EMF_LOST;
        end
        if (reframe_mode_i == emf_pkg::EMF_MODE_400MS && st_d != emf_pkg::EMF_LOCKED
            && t400_q == L400) begin
          st_d = emf_pkg::EMF_NOCRC;
        end
      end
      emf_pkg::EMF_LOCKED: begin
        t8_d = '0; t100_d = '0;
      end
      default: begin
        t8_d = '0; t100_d = '0;
      end
    endcase

    // loss of the primary alignment overrides the next state and the frame-loss pulse
    if (!basic_frame_locked_i || basic_loss) begin
      st_d  = emf_pkg::EMF_LOST;
      align_lost_d = basic_loss;
    end
    if (st_d != emf_pkg::EMF_LOCKED) begin
      rem_vld_d = 1'b0;
    end

    // once-a-second tick while multiframe lost
    if (st_q != emf_pkg::EMF_LOCKED) begin
      sec_d  = (sec_q == L1S) ? '0 : sec_q + 1'b1;
      tick_d = mf_lost_mon_en_i && (sec_q == L1S);
    end else begin
      sec_d = '0;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st_q <= emf_pkg::EMF_LOST;
      fr_q <= 4'h0; bc_q <= 8'h00; hist_q <= 6'h00;
      crc_q <= 4'h0; rem_q <= 4'h0; rem_vld_q <= 1'b0; cb_q <= 4'h0;
      ferr_q <= 2'h0; lock_q <= 1'b0; t400_run_q <= 1'b0;
      t8_q <= '0; t100_q <= '0; t400_q <= '0; sec_q <= '0;
      multiframe_lost_o <= 1'b1; frame_align_lost_o <= 1'b0;
      parallel_search_o <= 1'b0; primary_replace_o <= 1'b0;
      no_mfa_signal_o <= 1'b0; crc_inhibit_o <= 1'b0;
      crc_chk_o <= 1'b0; crc_err_o <= 1'b0; ebit_zero_o <= 1'b0;
      perf_mon_en_o <= 1'b0; sa6_mon_en_o <= 1'b0; mf_lost_sec_tick_o <= 1'b0;
    end else begin
      st_q <= st_d;
      fr_q <= fr_d; bc_q <= bc_d; hist_q <= hist_d;
      crc_q <= crc_d; rem_q <= rem_d; rem_vld_q <= rem_vld_d; cb_q <= cb_d;
      ferr_q <= ferr_d; lock_q <= lock_d; t400_run_q <= t400_run_d;
      t8_q <= t8_d; t100_q <= t100_d; t400_q <= t400_d; sec_q <= sec_d;
      multiframe_lost_o  <= (st_d != emf_pkg::EMF_LOCKED);
      frame_align_lost_o <= align_lost_d;
      parallel_search_o  <= psrch_d;
      primary_replace_o  <= repl_d;
      no_mfa_signal_o    <= (st_d == emf_pkg::EMF_NOCRC);
      crc_inhibit_o      <= (st_d == emf_pkg::EMF_NOCRC);
      crc_chk_o          <= chk_d;
      crc_err_o          <= err_d;
      ebit_zero_o        <= ez_d;
      perf_mon_en_o      <= (st_d == emf_pkg::EMF_LOCKED);
      sa6_mon_en_o       <= (st_d == emf_pkg::EMF_LOCKED);
      mf_lost_sec_tick_o <= tick_d;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb_chk @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_unlock_lost;
    !basic_frame_locked_i |=> multiframe_lost_o && !perf_mon_en_o;
  endproperty
  a_unlock_lost: assert property (p_unlock_lost) else $error("lock loss not reported");

  property p_ebit_gate;
    ebit_zero_o |-> !$past(multiframe_lost_o);
  endproperty
  a_ebit_gate: assert property (p_ebit_gate) else $error("e bit seen while lost");

  property p_crc_freeze;
    multiframe_lost_o |-> !perf_mon_en_o ##1 !crc_chk_o;
  endproperty
  a_crc_freeze: assert property (p_crc_freeze) else $error("crc active while lost");

  property p_sa6_freeze;
    multiframe_lost_o |-> !sa6_mon_en_o;
  endproperty
  a_sa6_freeze: assert property (p_sa6_freeze) else $error("sa6 active while lost");

  property p_err_has_chk;
    crc_err_o |-> crc_chk_o && $past(st_q) == emf_pkg::EMF_LOCKED;
  endproperty
  a_err_has_chk: assert property (p_err_has_chk) else $error("error without check");

  property p_t8_expiry;
    parallel_search_o |-> $past(t8_q) == L8 && t8_q == '0;
  endproperty
  a_t8_expiry: assert property (p_t8_expiry) else $error("parallel search off timer");

  property p_three_errs;
    basic_frame_locked_i && fas_err_i && ferr_q == 2'h2 |=> frame_align_lost_o;
  endproperty
  a_three_errs: assert property (p_three_errs) else $error("third bad word missed");

  property p_nocrc;
    no_mfa_signal_o |-> crc_inhibit_o && !crc_chk_o && !ebit_zero_o;
  endproperty
  a_nocrc: assert property (p_nocrc) else $error("crc work while inhibited");

  property p_sec_tick;
    mf_lost_sec_tick_o |-> $past(mf_lost_mon_en_i) && $past(multiframe_lost_o);
  endproperty
  a_sec_tick: assert property (p_sec_tick) else $error("tick outside lost state");

  property p_lock_via_confirm;
    $fell(multiframe_lost_o) |-> $past(st_q, 2) == emf_pkg::EMF_CONFIRM;
  endproperty
  a_lock_via_confirm: assert property (p_lock_via_confirm) else $error("lock w/o 2nd pattern");

  c_lock: cover property ($fell(multiframe_lost_o));
  c_crc_err: cover property (crc_err_o);
  c_parallel: cover property (parallel_search_o);
  c_nocrc: cover property ($rose(no_mfa_signal_o));

endmodule : emf_crc4_mf_sync

// ==== emf_line_model.sv ====
// partner model: remote e1 equipment sending crc-4 multiframes
module emf_line_model (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic sys_rst_i,
  // scenario controls
  input  wire logic mfa_on_i,
  input  wire logic bad_blk_i,
  input  wire logic ebit_i,
  // line side towards the block
  output logic      rx_bit_o,
  output logic      rx_bit_vld_o,
  output logic      rx_frame_start_o,
  output logic      rx_fas_frame_o
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [5:0] MFA = 6'h0b;
  localparam logic [6:0] FAW = 7'h1b;

  logic       ph;
  logic [7:0] bi;
  logic [3:0] fr;
  logic [3:0] crc;
  logic [3:0] rem;
  logic       b;
  logic       d;

  initial {rx_bit_o, rx_bit_vld_o, rx_frame_start_o, rx_fas_frame_o} = 4'h0;

  // ----------------------------------------
  // one bit every second clock
  // ----------------------------------------
  // between strobes the line shows the inverse, so a late sample is caught
  always @(negedge sys_clk_i) begin
    ph = ~ph;
    if (sys_rst_i) begin
      ph = 1'b0;
      bi = 8'h00;
      fr = 4'h0;
      crc = 4'h0;
      rem = 4'h0;
      rx_bit_vld_o     <= 1'b0;
      rx_frame_start_o <= 1'b0;
    end else if (ph) begin
      if (bi == 8'h00 && !fr[0]) begin
        b = mfa_on_i ? rem[3 - fr[2:1]] : 1'b1;
      end else if (bi == 8'h00) begin
        b = (fr[3:1] > 3'h5) ? ebit_i : (!mfa_on_i || MFA[5 - fr[3:1]]);
      end else if (bi < 8'h08) begin
        b = fr[0] ? (bi == 8'h01) : FAW[7 - bi];
      end else begin
        b = bi[0] ^ bi[3] ^ fr[1];
      end
      d = (bi == 8'h00 && !fr[0]) ? 1'b0 : b;
      crc = {crc[2:0], 1'b0} ^ ({4{d ^ crc[3]}} & 4'h3);
      // fault added on the line only, so the sent check bits describe clean data
      b = b ^ (bad_blk_i && fr == 4'h3 && bi == 8'h64);
      rx_bit_o         <= b;
      rx_bit_vld_o     <= 1'b1;
      rx_frame_start_o <= (bi == 8'h00);
      rx_fas_frame_o   <= ~fr[0];
      if (bi == 8'hff && fr[2:0] == 3'h7) begin
        rem = crc;
        crc = 4'h0;
      end
      fr = fr + {3'h0, bi == 8'hff};
      bi = bi + 8'h01;
    end else begin
      rx_bit_vld_o     <= 1'b0;
      rx_frame_start_o <= 1'b0;
      rx_bit_o         <= ~rx_bit_o;
    end
  end

endmodule : emf_line_model

// ==== emf_pkg.sv ====
// types for the crc-4 multiframe alignment block
package emf_pkg;

  // ----------------------------------------
  // reframe algorithm select
  // ----------------------------------------
  typedef enum logic [1:0] {
    EMF_MODE_8MS,
    EMF_MODE_100MS,
    EMF_MODE_400MS
  } emf_mode_e;

  // ----------------------------------------
  // multiframe alignment states
  // ----------------------------------------
  typedef enum logic [2:0] {
    EMF_LOST,
    EMF_SEARCH,
    EMF_CONFIRM,
    EMF_LOCKED,
    EMF_NOCRC
  } emf_state_e;

endpackage : emf_pkg

// ==== emf_regs.svh ====
// constants for the crc-4 multiframe alignment block
`ifndef EMF_REGS_SVH
`define EMF_REGS_SVH

// ----------------------------------------
// frame and multiframe layout
// ----------------------------------------
`define EMF_MF_FRAMES     16
`define EMF_FRAME_BITS    256
`define EMF_LAST_BIT      8'h00ff
`define EMF_MFAS_PAT      6'h0b
`define EMF_MFAS_FRAME    4'hb
`define EMF_CRC_POLY      4'h3
`define EMF_LOSS_FAS_ERRS 2'h3
`define EMF_MFL_MON_BIT   1

// ----------------------------------------
// timing, in microseconds and clock rate
// ----------------------------------------
`define EMF_CLK_MHZ       25
`define EMF_T8_US         8000
`define EMF_T100_US       100000
`define EMF_T400_US       400000
`define EMF_T1S_US        1000000

`endif

// ==== test_emf_crc4_mf_sync.sv ====
// self-checking bench for the crc-4 multiframe alignment block
module test_emf_crc4_mf_sync;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int C8  = 32'h0000_38a4;
  localparam int C100 = 32'h0000_3c8c;
  localparam int C400 = 32'h0000_4074;
  localparam int C1S = 32'h0000_04b0;
  localparam logic [31:0] MF = 32'h0000_2000;

  typedef struct packed {
    emf_pkg::emf_mode_e mode;
    logic [15:0]        len;
    logic [3:0]         exp;
  } emf_row_s;

  // watched pulses: replace, no pattern, frame loss, parallel search
  emf_row_s rows [3] = '{'{emf_pkg::EMF_MODE_8MS, 16'h3a98, 4'h1},
                         '{emf_pkg::EMF_MODE_100MS, 16'h3e80, 4'h3},
                         '{emf_pkg::EMF_MODE_400MS, 16'h4268, 4'h5}};

  logic sys_clk_i, sys_rst_i, rx_bit_i, rx_bit_vld_i, rx_frame_start_i, rx_fas_frame_i;
  logic basic_frame_locked_i, fas_err_i, fas_ok_i, parallel_align_i, mf_lost_mon_en_i;
  emf_pkg::emf_mode_e reframe_mode_i;
  logic multiframe_lost_o, frame_align_lost_o, parallel_search_o, primary_replace_o;
  logic no_mfa_signal_o, crc_inhibit_o, crc_chk_o, crc_err_o, ebit_zero_o;
  logic perf_mon_en_o, sa6_mon_en_o, mf_lost_sec_tick_o;
  logic mfa_on, bad_blk, ebit;
  logic [3:0]  w;
  logic [31:0] k, n_chk, n_err, n_eb, n_tk;
  int          num_errors, cmp_count;

  emf_crc4_mf_sync #(.C8(C8), .C100(C100), .C400(C400), .C1S(C1S)) emf_crc4_mf_sync_i (
    .sys_clk_i, .sys_rst_i, .rx_bit_i, .rx_bit_vld_i, .rx_frame_start_i, .rx_fas_frame_i,
    .basic_frame_locked_i, .fas_err_i, .fas_ok_i, .parallel_align_i, .reframe_mode_i,
    .mf_lost_mon_en_i, .multiframe_lost_o, .frame_align_lost_o, .parallel_search_o,
    .primary_replace_o, .no_mfa_signal_o, .crc_inhibit_o, .crc_chk_o, .crc_err_o,
    .ebit_zero_o, .perf_mon_en_o, .sa6_mon_en_o, .mf_lost_sec_tick_o);

  emf_line_model emf_line_model_i (
    .sys_clk_i, .sys_rst_i, .mfa_on_i(mfa_on), .bad_blk_i(bad_blk), .ebit_i(ebit),
    .rx_bit_o(rx_bit_i), .rx_bit_vld_o(rx_bit_vld_i), .rx_frame_start_o(rx_frame_start_i),
    .rx_fas_frame_o(rx_fas_frame_i));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // counts pulses at settled negedges; optionally stops once locked
  task automatic run(input logic [31:0] n, input logic stop, input logic clr);
    if (clr) begin
      w = 4'h0;
      {n_chk, n_err, n_eb, n_tk} = 128'h0;
    end
    k = 32'h0;
    while (k < n && !(stop && multiframe_lost_o === 1'b0)) begin
      @(negedge sys_clk_i);
      k = k + 32'h1;
      w = w | {primary_replace_o, no_mfa_signal_o, frame_align_lost_o, parallel_search_o};
      n_chk = n_chk + {31'h0, crc_chk_o};
      n_err = n_err + {31'h0, crc_err_o};
      n_eb = n_eb + {31'h0, ebit_zero_o};
      n_tk = n_tk + {31'h0, mf_lost_sec_tick_o};
    end
  endtask : run

  task automatic rst(input emf_pkg::emf_mode_e m, input logic mfa);
    @(negedge sys_clk_i);
    sys_rst_i = 1'b1;
    basic_frame_locked_i = 1'b0;
    reframe_mode_i = m;
    mfa_on = mfa;
    repeat (4'ha) @(negedge sys_clk_i);
    chk(32'({multiframe_lost_o, frame_align_lost_o, parallel_search_o, primary_replace_o,
             no_mfa_signal_o, crc_inhibit_o, crc_chk_o, crc_err_o, ebit_zero_o,
             perf_mon_en_o, sa6_mon_en_o, mf_lost_sec_tick_o}), 32'h0000_0800);
    sys_rst_i = 1'b0;
    basic_frame_locked_i = 1'b1;
  endtask : rst

  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    repeat (32'h0001_d4c0) @(posedge sys_clk_i);
    num_errors++;
    final_report();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    {sys_rst_i, basic_frame_locked_i, fas_err_i, fas_ok_i, parallel_align_i} = 5'h10;
    {mf_lost_mon_en_i, mfa_on, bad_blk, ebit} = 4'h9;
    reframe_mode_i = emf_pkg::EMF_MODE_8MS;
    num_errors = 0;
    cmp_count = 0;
    // far end sends no pattern: each mode shows its own timeout
    foreach (rows[i]) begin
      rst(rows[i].mode, 1'b0);
      run({16'h0000, rows[i].len}, 1'b0, 1'b1);
      chk(32'(w), 32'(rows[i].exp));
      chk(32'({multiframe_lost_o, crc_inhibit_o}), 32'({1'b1, rows[i].exp[2]}));
    end
    // interworking lock on a parallel alignment
    rst(emf_pkg::EMF_MODE_400MS, 1'b1);
    parallel_align_i = 1'b1;
    run(32'h0000_3e80, 1'b1, 1'b1);
    chk(32'(w), 32'h0000_0008);
    chk(32'({multiframe_lost_o, perf_mon_en_o, sa6_mon_en_o, crc_inhibit_o}), 32'h6);
    run(MF, 1'b0, 1'b1);
    bad_blk = 1'b1;
    ebit = 1'b0;
    run(MF, 1'b0, 1'b1);
    bad_blk = 1'b0;
    run(MF, 1'b0, 1'b0);
    chk(n_chk, 32'h0000_0004);
    chk(n_err, 32'h0000_0001);
    chk(n_eb, 32'h0000_0004);
    // error, error, good, then three errors in a row
    for (int i = 0; i < 6; i++) begin
      fas_err_i = (i != 2);
      fas_ok_i = (i == 2);
      run(32'h1, 1'b0, i == 0);
      fas_err_i = 1'b0;
      fas_ok_i = 1'b0;
      run(32'h3, 1'b0, 1'b0);
      if (i == 4) chk(32'(w[1]), 32'h0);
    end
    chk(32'(w[1]), 32'h1);
    // basic loss
    basic_frame_locked_i = 1'b0;
    parallel_align_i = 1'b0;
    run(32'h1, 1'b0, 1'b1);
    chk(32'({multiframe_lost_o, perf_mon_en_o, sa6_mon_en_o}), 32'h4);
    run(32'h0000_0258, 1'b0, 1'b1);
    run(32'h0000_12c0, 1'b0, 1'b1);
    chk(n_tk, 32'h0000_0004);
    chk(n_eb, 32'h0);
    chk(n_chk, 32'h0);
    mf_lost_mon_en_i = 1'b0;
    run(32'h0000_0960, 1'b0, 1'b1);
    chk(n_tk, 32'h0);
    final_report();
  end

endmodule : test_emf_crc4_mf_sync
